// ### include/amdc_pkg.sv
// register layout, field positions, reset values and carrier types
// for the auto mute and dither configuration bank.
// assumes one 40 MHz clock domain and a zero-wait ahb-lite slave port.
package amdc_pkg;

    // ==================================================
    // widths
    // ==================================================
    localparam int SAMPLE_W = 24; // modulator input word, two's complement
    localparam int DITHER_W = 11; // q0.11 dc dither value
    localparam int GAIN_W = 8; // gain outputs, unsigned q1.7
    localparam int DITHER_SHIFT = SAMPLE_W - 1 - 5 - DITHER_W; // 1.0 == 1/32 fs

    // ==================================================
    // register indices, byte address is four times the index
    // ==================================================
    localparam logic [7:0] IDX_AUTO_MUTE_CONFIG = 8'h41;
    localparam logic [7:0] IDX_PRIMARY_DITHER_GAIN = 8'h43;
    localparam logic [7:0] IDX_LEFT_DC_DITHER_HIGH = 8'h44;
    localparam logic [7:0] IDX_LEFT_DC_DITHER_LOW = 8'h45;
    localparam logic [7:0] IDX_RIGHT_DC_DITHER_LOW = 8'h46;
    localparam logic [7:0] IDX_RIGHT_DC_DITHER_HIGH = 8'h47;

    // ==================================================
    // reset values
    // ==================================================
    localparam logic [7:0] RST_AUTO_MUTE_CONFIG = 8'h07;
    localparam logic [7:0] RST_PRIMARY_DITHER_GAIN = 8'h00;
    localparam logic [7:0] RST_DC_DITHER = 8'h00;

    // ==================================================
    // field positions
    // ==================================================
    localparam int POS_AUTO_MUTE_PAIRING = 2;
    localparam int POS_AUTO_MUTE_BIT1_ENABLE = 1; // gates the right channel
    localparam int POS_AUTO_MUTE_BIT0_ENABLE = 0; // gates the left channel
    localparam int POS_LEFT_AC = 6;
    localparam int POS_RIGHT_AC = 4;
    localparam int POS_LEFT_ELEMENT = 2;
    localparam int POS_RIGHT_ELEMENT = 0;
    localparam int DC_HIGH_W = 3; // upper dither bits in the high register

    // ==================================================
    // gain encodings, unsigned q1.7
    // ==================================================
    localparam logic [GAIN_W-1:0] GAIN_0P125 = 8'h10;
    localparam logic [GAIN_W-1:0] GAIN_0P25 = 8'h20;
    localparam logic [GAIN_W-1:0] GAIN_0P5 = 8'h40;
    localparam logic [GAIN_W-1:0] GAIN_1P0 = 8'h80;

    // ==================================================
    // carriers
    // ==================================================
    typedef struct packed {
        logic strobe; // one new sample pair this cycle
        logic [SAMPLE_W-1:0] left; // left modulator input
        logic [SAMPLE_W-1:0] right; // right modulator input
    } amdc_sample_type;

    typedef struct packed {
        logic [GAIN_W-1:0] left_ac;
        logic [GAIN_W-1:0] right_ac;
        logic [GAIN_W-1:0] left_element;
        logic [GAIN_W-1:0] right_element;
    } amdc_gain_type;

endpackage : amdc_pkg

// ### src/amdc_bank.sv
// auto mute grouping and primary modulator dither bank, with ahb-lite
// register access, zero-sample detection, mute flags and dc dither add.
// assumes samples and the zero-detect length come from logic on hclk.
`timescale 1ns/100ps
`default_nettype none

module amdc_bank #(
    parameter int ZERO_CNT_W = 16 // width of the zero run counter
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [ZERO_CNT_W-1:0] zero_detect_duration_reg,
    input wire amdc_pkg::amdc_sample_type sample_in,
    output amdc_pkg::amdc_sample_type sample_out,
    output logic left_auto_mute,
    output logic right_auto_mute,
    output amdc_pkg::amdc_gain_type gain_out
);

    // ==================================================
    // elaboration checks
    // ==================================================
    if (ZERO_CNT_W < 1 || ZERO_CNT_W > 31) begin : g_bad_width
        $error("zero counter width out of range");
    end
    if (amdc_pkg::DITHER_SHIFT < 0) begin : g_bad_shift
        $error("sample word too narrow for dc dither");
    end

    // ==================================================
    // state
    // ==================================================
    typedef struct packed {
        logic [7:0] auto_mute_config; // pairing and enables
        logic [7:0] primary_dither_gain; // ac and element gain codes
        logic [7:0] left_dc_dither_high;
        logic [7:0] left_dc_dither_low;
        logic [7:0] right_dc_dither_low;
        logic [7:0] right_dc_dither_high;
        logic wr_pend; // write data phase pending
        logic [7:0] wr_idx; // index of pending write
        logic [31:0] rdata; // read data for the data phase
        logic [ZERO_CNT_W-1:0] left_zeros; // consecutive zero run
        logic [ZERO_CNT_W-1:0] right_zeros;
        logic left_mute;
        logic right_mute;
        amdc_pkg::amdc_sample_type out; // dithered samples
        amdc_pkg::amdc_gain_type gain; // decoded gains
    } amdc_state_type;

    amdc_state_type state; // registered state
    amdc_state_type next_state; // combinational next state

    // ==================================================
    // helpers
    // ==================================================
    // register readback by index, zero for unmapped
    function automatic logic [7:0] amdc_read(input amdc_state_type s, input logic [7:0] idx);
        case (idx)
            amdc_pkg::IDX_AUTO_MUTE_CONFIG: amdc_read = s.auto_mute_config;
            amdc_pkg::IDX_PRIMARY_DITHER_GAIN: amdc_read = s.primary_dither_gain;
            amdc_pkg::IDX_LEFT_DC_DITHER_HIGH: amdc_read = s.left_dc_dither_high;
            amdc_pkg::IDX_LEFT_DC_DITHER_LOW: amdc_read = s.left_dc_dither_low;
            amdc_pkg::IDX_RIGHT_DC_DITHER_LOW: amdc_read = s.right_dc_dither_low;
            amdc_pkg::IDX_RIGHT_DC_DITHER_HIGH: amdc_read = s.right_dc_dither_high;
            default: amdc_read = 8'h00;
        endcase
    endfunction : amdc_read

    // ac dither gain decode; codes above 01 fall back to the smallest gain
    function automatic logic [amdc_pkg::GAIN_W-1:0] amdc_ac_gain(input logic [1:0] code);
        case (code)
            2'h1: amdc_ac_gain = amdc_pkg::GAIN_0P25;
            default: amdc_ac_gain = amdc_pkg::GAIN_0P125;
        endcase
    endfunction : amdc_ac_gain

    // element dither gain decode; reserved codes must not be written
    function automatic logic [amdc_pkg::GAIN_W-1:0] amdc_element_gain(input logic [1:0] code);
        case (code)
            2'h1: amdc_element_gain = amdc_pkg::GAIN_1P0;
            default: amdc_element_gain = amdc_pkg::GAIN_0P5;
        endcase
    endfunction : amdc_element_gain

    // zero run counter step, saturating so long silence stays qualified
    function automatic logic [ZERO_CNT_W-1:0] amdc_zero_step(
        input logic [ZERO_CNT_W-1:0] cnt,
        input logic [amdc_pkg::SAMPLE_W-1:0] smp
    );
        if (smp != '0) begin
            amdc_zero_step = '0;
        end else if (cnt == '1) begin
            amdc_zero_step = cnt;
        end else begin
            amdc_zero_step = cnt + 1'b1;
        end
    endfunction : amdc_zero_step

    // dc dither add: the code lsb weighs 2^-11 of fs/32
    function automatic logic [amdc_pkg::SAMPLE_W-1:0] amdc_add_dither(
        input logic [amdc_pkg::SAMPLE_W-1:0] smp,
        input logic [amdc_pkg::DITHER_W-1:0] code
    );
        logic [amdc_pkg::SAMPLE_W-1:0] wide;
        wide = amdc_pkg::SAMPLE_W'(code) << amdc_pkg::DITHER_SHIFT;
        amdc_add_dither = smp + wide;
    endfunction : amdc_add_dither

    // ==================================================
    // decoded views of the registers
    // ==================================================
    logic pairing; // auto_mute_pairing
    logic left_enable; // from auto_mute_bit0_enable
    logic right_enable; // from auto_mute_bit1_enable
    logic left_qual; // left run long enough and enabled
    logic right_qual;
    logic left_run; // raw zero run reached duration
    logic right_run;
    logic [amdc_pkg::DITHER_W-1:0] left_primary_dc_offset;
    logic [amdc_pkg::DITHER_W-1:0] right_primary_dc_offset;
    logic addr_phase; // valid transfer taken this cycle

    always_comb begin
        pairing = state.auto_mute_config[amdc_pkg::POS_AUTO_MUTE_PAIRING];
        right_enable = state.auto_mute_config[amdc_pkg::POS_AUTO_MUTE_BIT1_ENABLE];
        left_enable = state.auto_mute_config[amdc_pkg::POS_AUTO_MUTE_BIT0_ENABLE];
        // zero run reaches length; an empty run never qualifies, so a zero length qualifies after one zero
        left_run = (state.left_zeros != '0) && (state.left_zeros >= zero_detect_duration_reg);
        right_run = (state.right_zeros != '0) && (state.right_zeros >= zero_detect_duration_reg);
        left_qual = left_run && left_enable;
        right_qual = right_run && right_enable;
        left_primary_dc_offset = {state.left_dc_dither_high[amdc_pkg::DC_HIGH_W-1:0],
                                  state.left_dc_dither_low};
        right_primary_dc_offset = {state.right_dc_dither_high[amdc_pkg::DC_HIGH_W-1:0],
                                   state.right_dc_dither_low};
        addr_phase = hsel && hready && htrans[1];
    end

    // ==================================================
    // next state
    // ==================================================
    always_comb begin
        next_state = state;
        // bus: write lands in the data phase, read data is prepared early
        next_state.wr_pend = addr_phase && hwrite;
        next_state.wr_idx = haddr[9:2];
        if (addr_phase && !hwrite) begin
            next_state.rdata = {24'h000000, amdc_read(state, haddr[9:2])};
        end else begin
            next_state.rdata = 32'h00000000;
        end
        if (state.wr_pend) begin
            case (state.wr_idx)
                amdc_pkg::IDX_AUTO_MUTE_CONFIG: begin
                    next_state.auto_mute_config = hwdata[7:0];
                end
                amdc_pkg::IDX_PRIMARY_DITHER_GAIN: begin
                    next_state.primary_dither_gain = hwdata[7:0];
                end
                amdc_pkg::IDX_LEFT_DC_DITHER_HIGH: begin
                    next_state.left_dc_dither_high = hwdata[7:0];
                end
                amdc_pkg::IDX_LEFT_DC_DITHER_LOW: begin
                    next_state.left_dc_dither_low = hwdata[7:0];
                end
                amdc_pkg::IDX_RIGHT_DC_DITHER_LOW: begin
                    next_state.right_dc_dither_low = hwdata[7:0];
                end
                amdc_pkg::IDX_RIGHT_DC_DITHER_HIGH: begin
                    next_state.right_dc_dither_high = hwdata[7:0];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        next_state.out.strobe = sample_in.strobe;
        if (sample_in.strobe) begin
            next_state.left_zeros = amdc_zero_step(state.left_zeros, sample_in.left);
            next_state.right_zeros = amdc_zero_step(state.right_zeros, sample_in.right);
            next_state.out.left = amdc_add_dither(sample_in.left, left_primary_dc_offset);
            next_state.out.right = amdc_add_dither(sample_in.right, right_primary_dc_offset);
        end
        if (pairing) begin
            next_state.left_mute = left_qual && right_qual;
            next_state.right_mute = left_qual && right_qual;
        end else begin
            next_state.left_mute = left_qual;
            next_state.right_mute = right_qual;
        end
        next_state.gain.left_ac = amdc_ac_gain(state.primary_dither_gain[amdc_pkg::POS_LEFT_AC +: 2]);
        next_state.gain.right_ac = amdc_ac_gain(state.primary_dither_gain[amdc_pkg::POS_RIGHT_AC +: 2]);
        next_state.gain.left_element =
            amdc_element_gain(state.primary_dither_gain[amdc_pkg::POS_LEFT_ELEMENT +: 2]);
        next_state.gain.right_element =
            amdc_element_gain(state.primary_dither_gain[amdc_pkg::POS_RIGHT_ELEMENT +: 2]);
    end

    // ==================================================
    // state register
    // ==================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
            state.auto_mute_config <= amdc_pkg::RST_AUTO_MUTE_CONFIG;
            state.primary_dither_gain <= amdc_pkg::RST_PRIMARY_DITHER_GAIN;
            state.left_dc_dither_high <= amdc_pkg::RST_DC_DITHER;
            state.left_dc_dither_low <= amdc_pkg::RST_DC_DITHER;
            state.right_dc_dither_low <= amdc_pkg::RST_DC_DITHER;
            state.right_dc_dither_high <= amdc_pkg::RST_DC_DITHER;
            state.gain <= {amdc_pkg::GAIN_0P125, amdc_pkg::GAIN_0P125,
                           amdc_pkg::GAIN_0P5, amdc_pkg::GAIN_0P5};
        end else begin
            state <= next_state;
        end
    end

    // ==================================================
    // outputs
    // ==================================================
    // zero wait states, so the slave is always ready and always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state.rdata;
    assign sample_out = state.out;
    assign left_auto_mute = state.left_mute;
    assign right_auto_mute = state.right_mute;
    assign gain_out = state.gain;

    // ==================================================
    // assertions
    // ==================================================
    default clocking amdc_cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    indep_left_a: assert property (
        ($past(!pairing) && $past(left_qual)) |-> left_auto_mute
    ) else $error("independent left mute missing");

    paired_equal_a: assert property (
        (left_auto_mute != right_auto_mute) |-> !$past(pairing)
    ) else $error("paired channels muted apart");

    zero_cause_a: assert property (
        left_auto_mute |-> $past(left_run)
    ) else $error("left mute without zero run");

    right_gate_a: assert property (
        $past(!right_enable) |-> !right_auto_mute
    ) else $error("right muted while disabled");

    left_gate_a: assert property (
        $past(!left_enable) |-> !left_auto_mute
    ) else $error("left muted while disabled");

    paired_left_block_a: assert property (
        ($past(pairing) && $past(!right_enable)) |-> !left_auto_mute
    ) else $error("paired left muted with right disabled");

    paired_right_block_a: assert property (
        ($past(pairing) && $past(!left_enable)) |-> !right_auto_mute
    ) else $error("paired right muted with left disabled");

    left_ac_gain_a: assert property (
        ($past(state.primary_dither_gain[7:6]) == 2'h1) |-> (gain_out.left_ac == 8'h20)
    ) else $error("left ac gain decode wrong");

    right_ac_gain_a: assert property (
        ($past(state.primary_dither_gain[5:4]) == 2'h0) |-> (gain_out.right_ac == 8'h10)
    ) else $error("right ac gain decode wrong");

    left_element_a: assert property (
        ($past(state.primary_dither_gain[3:2]) == 2'h1) |-> (gain_out.left_element == 8'h80)
    ) else $error("left element gain decode wrong");

    right_element_a: assert property (
        ($past(state.primary_dither_gain[1:0]) == 2'h0) |-> (gain_out.right_element == 8'h40)
    ) else $error("right element gain decode wrong");

    left_dither_add_a: assert property (
        sample_in.strobe |=> (sample_out.left ==
            $past(sample_in.left) + ({13'h0000, $past(left_primary_dc_offset)} << 7))
    ) else $error("left dc dither sum wrong");

    right_dither_add_a: assert property (
        sample_in.strobe |=> (sample_out.right ==
            $past(sample_in.right) + ({13'h0000, $past(right_primary_dc_offset)} << 7))
    ) else $error("right dc dither sum wrong");

    left_split_a: assert property (
        (sample_in.strobe && sample_in.left == '0) |=>
            (sample_out.left[17:15] == $past(state.left_dc_dither_high[2:0]))
    ) else $error("left dither high bits misplaced");

    write_read_a: assert property (
        (addr_phase && hwrite && haddr[9:2] == 8'h45) ##1 !addr_phase ##1 !addr_phase
            ##1 (addr_phase && !hwrite && haddr[9:2] == 8'h45)
            |=> (hrdata[7:0] == $past(hwdata[7:0], 3))
    ) else $error("left low dither readback wrong");

    paired_mute_c: cover property (pairing && left_auto_mute && right_auto_mute);
    indep_mute_c: cover property (!pairing && left_auto_mute && !right_auto_mute);
    dither_c: cover property (sample_in.strobe && left_primary_dc_offset != '0);
    reg_write_c: cover property (state.wr_pend && state.wr_idx == 8'h43);

endmodule : amdc_bank

`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the auto mute and dither configuration bank.
// assumes amdc_pkg is compiled first and amdc_bank has a zero-wait ahb-lite port.
`timescale 1ns/100ps
`default_nettype none

module tb;
    // ==================================================
    // stimulus and observed signals
    // ==================================================
    logic hclk = 1'b0;
    logic hresetn = 1'b0; // held low for eight cycles
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // whole words only
    logic [31:0] hwdata = 32'h0;
    wire logic hready; // single slave drives the bus ready
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [15:0] zero_detect_duration_reg = 16'h0002; // short run keeps the test quick
    amdc_pkg::amdc_sample_type sample_in = '0;
    amdc_pkg::amdc_sample_type sample_out;
    logic left_auto_mute;
    logic right_auto_mute;
    amdc_pkg::amdc_gain_type gain_out;
    int fails = 0;
    int tests_run = 0;

    assign hready = hreadyout;

    // free-running 40 mhz clock
    always #12.5 hclk = ~hclk;

    amdc_bank #(.ZERO_CNT_W(16)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .zero_detect_duration_reg(zero_detect_duration_reg), .sample_in(sample_in),
        .sample_out(sample_out), .left_auto_mute(left_auto_mute),
        .right_auto_mute(right_auto_mute), .gain_out(gain_out)
    );

    // ==================================================
    // reporting
    // ==================================================
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ==================================================
    // bus and sample drivers
    // ==================================================
    // hready and read data are taken at the rising edge, before that edge's update lands
    task automatic wait_ready(output logic [31:0] rd);
        int n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        while (!rdy && n < 50) begin
            @(posedge hclk);
            rd = hrdata;
            rdy = (hready === 1'b1);
            n++;
        end
        // a bus that never answers ends the run
        if (!rdy) begin
            fails++;
            wrap_up();
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        wait_ready(rd);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        wait_ready(rd);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, d, rd);
    endtask : wr

    task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, rd);
        check(rd, {24'h0, exp});
    endtask : rd_check

    // one sample pair, returns mid-cycle after the output register has loaded
    task automatic send(input logic [23:0] l, input logic [23:0] r);
        @(posedge hclk);
        sample_in <= '{strobe: 1'b1, left: l, right: r};
        @(posedge hclk);
        sample_in.strobe <= 1'b0;
        @(negedge hclk);
    endtask : send

    // ==================================================
    // scenarios
    // ==================================================
    task automatic t_reset();
        rd_check(amdc_pkg::IDX_AUTO_MUTE_CONFIG, amdc_pkg::RST_AUTO_MUTE_CONFIG);
        rd_check(amdc_pkg::IDX_PRIMARY_DITHER_GAIN, amdc_pkg::RST_PRIMARY_DITHER_GAIN);
        rd_check(amdc_pkg::IDX_LEFT_DC_DITHER_HIGH, amdc_pkg::RST_DC_DITHER);
        rd_check(amdc_pkg::IDX_RIGHT_DC_DITHER_HIGH, amdc_pkg::RST_DC_DITHER);
        check(gain_out, {amdc_pkg::GAIN_0P125, amdc_pkg::GAIN_0P125,
                         amdc_pkg::GAIN_0P5, amdc_pkg::GAIN_0P5});
        // unmapped index: write dropped, read gives zero
        wr(8'h42, 8'hff);
        rd_check(8'h42, 8'h00);
        check(hresp, 1'b0);
    endtask : t_reset

    // only codes 00 and 01 go into the element gain fields
    task automatic t_gain();
        wr(amdc_pkg::IDX_PRIMARY_DITHER_GAIN, 8'h44);
        repeat (2) @(posedge hclk);
        check(gain_out, {amdc_pkg::GAIN_0P25, amdc_pkg::GAIN_0P125,
                         amdc_pkg::GAIN_1P0, amdc_pkg::GAIN_0P5});
        wr(amdc_pkg::IDX_PRIMARY_DITHER_GAIN, 8'h11);
        repeat (2) @(posedge hclk);
        check(gain_out, {amdc_pkg::GAIN_0P125, amdc_pkg::GAIN_0P25,
                         amdc_pkg::GAIN_0P5, amdc_pkg::GAIN_1P0});
        rd_check(amdc_pkg::IDX_PRIMARY_DITHER_GAIN, 8'h11);
    endtask : t_gain

    // dither lands at bit 7 of the 24-bit word: 2^-11 of fs/32
    task automatic t_dither();
        wr(amdc_pkg::IDX_LEFT_DC_DITHER_HIGH, 8'hfd);
        rd_check(amdc_pkg::IDX_LEFT_DC_DITHER_HIGH, 8'hfd);
        wr(amdc_pkg::IDX_LEFT_DC_DITHER_LOW, 8'h03);
        rd_check(amdc_pkg::IDX_LEFT_DC_DITHER_LOW, 8'h03);
        wr(amdc_pkg::IDX_RIGHT_DC_DITHER_LOW, 8'h01);
        wr(amdc_pkg::IDX_RIGHT_DC_DITHER_HIGH, 8'h02);
        send(24'h000000, 24'h000100);
        check(sample_out.left, 24'h503 << 7);
        check(sample_out.right, 24'h100 + (24'h201 << 7));
        check(sample_out.strobe, 1'b1);
        wr(amdc_pkg::IDX_LEFT_DC_DITHER_HIGH, 8'h00);
        wr(amdc_pkg::IDX_LEFT_DC_DITHER_LOW, 8'h01);
        wr(amdc_pkg::IDX_RIGHT_DC_DITHER_LOW, 8'h00);
        wr(amdc_pkg::IDX_RIGHT_DC_DITHER_HIGH, 8'h00);
        send(24'hffffff, 24'h000123);
        check(sample_out.left, 24'(24'hffffff + (24'h001 << 7)));
        check(sample_out.right, 24'h000123);
    endtask : t_dither

    // nonzero pair clears both runs; one zero is short of the run length of two
    task automatic mute_case(input logic [7:0] cfg, input logic lz, input logic rz,
                             input logic el, input logic er);
        wr(amdc_pkg::IDX_AUTO_MUTE_CONFIG, cfg);
        send(24'h000011, 24'h000011);
        send(lz ? 24'h0 : 24'h11, rz ? 24'h0 : 24'h11);
        @(posedge hclk);
        @(negedge hclk);
        check(left_auto_mute, 1'b0);
        check(right_auto_mute, 1'b0);
        repeat (2) send(lz ? 24'h0 : 24'h11, rz ? 24'h0 : 24'h11);
        @(posedge hclk);
        @(negedge hclk);
        check(left_auto_mute, el);
        check(right_auto_mute, er);
    endtask : mute_case

    // ==================================================
    // main sequence
    // ==================================================
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_gain();
        t_dither();
        mute_case(8'h03, 1'b1, 1'b0, 1'b1, 1'b0);
        mute_case(8'h07, 1'b1, 1'b0, 1'b0, 1'b0);
        mute_case(8'h07, 1'b1, 1'b1, 1'b1, 1'b1);
        mute_case(8'h01, 1'b1, 1'b1, 1'b1, 1'b0);
        mute_case(8'h02, 1'b1, 1'b1, 1'b0, 1'b1);
        mute_case(8'h05, 1'b1, 1'b1, 1'b0, 1'b0);
        mute_case(8'h06, 1'b1, 1'b1, 1'b0, 1'b0);
        wrap_up();
    end
endmodule : tb

`default_nettype wire
